/* File: hdl/ast_params.svh */
// constants for the async serial transceiver: offsets, reset values, counts
// assumes inclusion by the design, checker and testbench files by bare name
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AST_OFF_CTRL    8'h00
`define AST_OFF_CMD     8'h04
`define AST_OFF_TXDATA  8'h08
`define AST_OFF_TXSTA   8'h0C
`define AST_OFF_RXDATA  8'h10
`define AST_OFF_RXSTA   8'h14
`define AST_ADDR_LSB    2
`define AST_ADDR_MSB    7

// ----------------------------------------
// reset values
// ----------------------------------------
`define AST_CTRL_RST    8'h05
`define AST_CMD_RST     8'h00
`define AST_DATA_RST    8'h00

// ----------------------------------------
// ahb codes
// ----------------------------------------
`define AST_HTRANS_NSEQ 2'h2
`define AST_HSIZE_WORD  3'h2

// ----------------------------------------
// word framing
// ----------------------------------------
`define AST_LAST_BIT_8  3'h7
`define AST_LAST_BIT_7  3'h6
`define AST_MAX_PRESC   3'h2

// ----------------------------------------
// oscillator edges per bit, by baud_code
// ----------------------------------------
`define AST_DIV_BR0     8'h38
`define AST_DIV_BR1     8'h1C
`define AST_DIV_BR2     8'h0E
`define AST_DIV_BR3     8'h07
`define AST_DIV_BR4     8'h80
`define AST_DIV_BR5     8'h40
`define AST_DIV_BR6     8'h0B
`define AST_DIV_BR7     8'h10

`endif

/* File: hdl/ast_pkg.sv */
// types shared by the async serial transceiver
// assumes ast_params.svh for the numeric constants
package ast_pkg;

    typedef logic [9:0] ast_div_type;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    typedef struct packed {
        logic       echo_enable;
        logic       rx_enable_a;
        logic       tx_enable;
        logic       rx_line_invert;
        logic       tx_line_invert;
        logic [2:0] baud_code;
    } ast_ctrl_type;

    // ----------------------------------------
    // command register fields
    // ----------------------------------------
    typedef struct packed {
        logic       crystal_clock_select;
        logic       rx_enable_b;
        logic [2:0] clock_prescale_sel;
        logic       parity_mode;
        logic       parity_enable;
        logic       word_length_sel;
    } ast_cmd_type;

    // ----------------------------------------
    // receive status fields
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] unused;
        logic       rx_start_err;
        logic       rx_parity_err;
        logic       rx_frame_err;
        logic       rx_overrun_err;
        logic       rx_active;
        logic       rx_holding_full;
    } ast_rxsta_type;

    typedef enum logic [4:0] {
        AST_IDLE   = 5'b0_0001,
        AST_START  = 5'b0_0010,
        AST_DATA   = 5'b0_0100,
        AST_PARITY = 5'b0_1000,
        AST_STOP   = 5'b1_0000
    } ast_state_type;

endpackage

/* File: hdl/ast_uart.sv */
// async serial transceiver: ahb-lite register slave, baud generator,
// transmitter and receiver with one holding register each
// assumes oscillator and rx inputs synchronous to i_clk and far slower
//
// Functional notes
// (RQ1) echo drives tx from rx xor tx invert
// (RQ2) reception enabled when either enable bit set
// (RQ3) transmit only while tx_enable set; code gates only the load, a loaded word still finishes after it clears
// (RQ4) invert bits flip rx and tx lines
// (RQ5) crystal_clock_select picks rc or crystal source
// (RQ6) rc 1228800 prescale 001 baud table
// (RQ7) rc 1843200 prescale 000, 2457600 uses 010
// (RQ8) crystal 32768 prescale 001 baud table
// (RQ9) software enables crystal before using it
// (RQ10) 7 or 8 bits, optional odd/even parity
// (RQ11) tx data write sets tx_holding_full
// (RQ12) idle transmitter loads word, clears full
// (RQ13) tx interrupt when holding register empties
// (RQ14) tx_active high while shifting a word
// (RQ15) data bits least significant first
// (RQ16) software writes only when holding empty
// (RQ17) rx_active set on start bit
// (RQ18) stop bit moves word, sets rx_holding_full
// (RQ19) reading rx data clears rx_holding_full
// (RQ20) rx status write clears overrun flag
// (RQ21) tx on line 1, rx on line 0
// (RQ22) rx interrupt with rx_holding_full set
// (RQ23) unread word overwritten sets overrun
// (RQ24) start and parity errors updated per word
// (RQ25) frame error when stop bit missing
// (RQ26) reset clears all, baud_code becomes 101
`timescale 1ns/1ps
`include "ast_params.svh"

module ast_uart (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_rc_osc,
    input  wire logic        i_xtal_osc,
    input  wire logic        i_rx,
    output logic             o_tx,
    output logic      [1:0]  o_high_priority_irq_line
);
    import ast_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // oscillator edges per bit: prescale doubles per step up to 010, baud_code picks the divisor
    // 110 uses 11 where the ideal is 10.67, about 3 percent slow
    function automatic ast_div_type bit_period(input logic [2:0] presc, input logic [2:0] br);
        logic [7:0] div;
        logic [1:0] sh;
        div = 8'h00;
        // prescale codes above 2 act as 2
        sh  = (presc > `AST_MAX_PRESC) ? 2'(`AST_MAX_PRESC) : presc[1:0];
        case (br)
            3'h0: div = `AST_DIV_BR0;
            3'h1: div = `AST_DIV_BR1;
            3'h2: div = `AST_DIV_BR2;
            3'h3: div = `AST_DIV_BR3;
            3'h4: div = `AST_DIV_BR4;
            3'h5: div = `AST_DIV_BR5;
            3'h6: div = `AST_DIV_BR6;
            default: div = `AST_DIV_BR7;
        endcase
        bit_period = ast_div_type'({2'h0, div} << sh);
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input logic wl, input logic even);
        logic p;
        p = wl ? ^d : ^d[6:0];
        par_bit = even ? p : ~p;
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    ast_ctrl_type  ctrl_ff;
    ast_cmd_type   cmd_ff;
    ast_rxsta_type rxsta;
    logic [7:0]    txdata_ff;
    logic [7:0]    rxdata_ff;
    logic          tx_full_ff;
    logic          rx_full_ff;
    logic          ovr_ff;
    logic          serr_ff;
    logic          perr_ff;
    logic          ferr_ff;
    logic          wr_ff;
    logic [5:0]    waddr_ff;
    logic          osc_q_ff;
    logic [1:0]    irq_ff;
    logic          tx_out_ff;
    // transmit state sits here because the status read mux needs it
    ast_state_type tx_st_ff;
    wire           tx_busy = (tx_st_ff != AST_IDLE); // RQ14

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire        acc     = i_hsel & i_hready & (i_htrans == `AST_HTRANS_NSEQ) & (i_hsize == `AST_HSIZE_WORD);
    wire        rd_acc  = acc & ~i_hwrite;
    wire [5:0]  aidx    = i_haddr[`AST_ADDR_MSB:`AST_ADDR_LSB];
    wire [7:0]  abyte   = {aidx, 2'h0};
    wire [7:0]  wbyte   = {waddr_ff, 2'h0};
    wire        wr_ctrl = wr_ff & (wbyte == `AST_OFF_CTRL);
    wire        wr_cmd  = wr_ff & (wbyte == `AST_OFF_CMD);
    wire        wr_txd  = wr_ff & (wbyte == `AST_OFF_TXDATA);
    wire        wr_rxs  = wr_ff & (wbyte == `AST_OFF_RXSTA);
    wire        rd_rxd  = rd_acc & (abyte == `AST_OFF_RXDATA);

    logic [7:0] rd_mux;
    always_comb begin
        if (abyte == `AST_OFF_CTRL) begin
            rd_mux = ctrl_ff;
        end else if (abyte == `AST_OFF_CMD) begin
            rd_mux = cmd_ff;
        end else if (abyte == `AST_OFF_TXDATA) begin
            rd_mux = txdata_ff;
        end else if (abyte == `AST_OFF_TXSTA) begin
            rd_mux = {6'h00, tx_busy, tx_full_ff};
        end else if (abyte == `AST_OFF_RXDATA) begin
            rd_mux = rxdata_ff;
        end else if (abyte == `AST_OFF_RXSTA) begin
            rd_mux = rxsta;
        end else begin
            rd_mux = `AST_DATA_RST;
        end
    end

    // zero wait states; reads are captured in the address phase, so a read right
    // behind a write to the same register returns the old value
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ff       <= 1'b0;
            waddr_ff    <= 6'h00;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end else begin
            wr_ff       <= acc & i_hwrite;
            waddr_ff    <= aidx;
            o_hrdata    <= rd_acc ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_ff   <= `AST_CTRL_RST; // RQ26
            cmd_ff    <= `AST_CMD_RST;  // RQ26
            txdata_ff <= `AST_DATA_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= i_hwdata[7:0];
            end
            if (wr_cmd) begin
                cmd_ff <= i_hwdata[7:0];
            end
            if (wr_txd) begin
                txdata_ff <= i_hwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // baud source
    // ----------------------------------------
    wire         osc_src  = cmd_ff.crystal_clock_select ? i_xtal_osc : i_rc_osc; // RQ5
    // switching the source may cost one stray tick; a word in flight is then off by one tick
    wire         tick     = osc_src & ~osc_q_ff;
    wire ast_div_type period = bit_period(cmd_ff.clock_prescale_sel, ctrl_ff.baud_code); // RQ6 RQ7 RQ8
    wire [2:0]   last_bit = cmd_ff.word_length_sel ? `AST_LAST_BIT_8 : `AST_LAST_BIT_7; // RQ10

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_q_ff <= 1'b0;
        end else begin
            osc_q_ff <= osc_src;
        end
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    ast_div_type   tx_cnt_ff;
    logic [2:0]    tx_idx_ff;
    logic [7:0]    tx_sh_ff;
    logic          tx_line_ff;
    wire           tx_load = (tx_st_ff == AST_IDLE) & tx_full_ff & ctrl_ff.tx_enable; // RQ3 RQ12
    wire           tx_step = tick & (tx_cnt_ff == '0);

    // a write in the load cycle keeps the flag set, so the new word waits its turn
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_full_ff <= 1'b0;
        end else if (wr_txd) begin
            tx_full_ff <= 1'b1; // RQ11
        end else if (tx_load) begin
            tx_full_ff <= 1'b0; // RQ12
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_st_ff   <= AST_IDLE;
            tx_cnt_ff  <= '0;
            tx_idx_ff  <= 3'h0;
            tx_sh_ff   <= `AST_DATA_RST;
            tx_line_ff <= 1'b1;
        end else if (tx_load) begin
            tx_st_ff   <= AST_START;
            tx_sh_ff   <= txdata_ff;
            tx_cnt_ff  <= period - 1'b1;
            tx_line_ff <= 1'b0;
        end else if (tick & (tx_cnt_ff != '0)) begin
            tx_cnt_ff <= tx_cnt_ff - 1'b1;
        end else if (tx_step) begin
            tx_cnt_ff <= period - 1'b1;
            case (tx_st_ff)
                AST_START: begin
                    tx_st_ff   <= AST_DATA;
                    tx_idx_ff  <= 3'h0;
                    tx_line_ff <= tx_sh_ff[0]; // RQ15
                end
                AST_DATA: begin
                    if (tx_idx_ff == last_bit) begin
                        tx_st_ff   <= cmd_ff.parity_enable ? AST_PARITY : AST_STOP;
                        tx_line_ff <= cmd_ff.parity_enable ?
                                      par_bit(tx_sh_ff, cmd_ff.word_length_sel, cmd_ff.parity_mode) : 1'b1; // RQ10
                    end else begin
                        tx_idx_ff  <= tx_idx_ff + 1'b1;
                        tx_line_ff <= tx_sh_ff[tx_idx_ff + 1'b1]; // RQ15
                    end
                end
                AST_PARITY: begin
                    tx_st_ff   <= AST_STOP;
                    tx_line_ff <= 1'b1;
                end
                default: begin
                    tx_st_ff   <= AST_IDLE;
                    tx_line_ff <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    ast_state_type rx_st_ff;
    ast_div_type   rx_cnt_ff;
    logic [2:0]    rx_idx_ff;
    logic [7:0]    rx_sh_ff;
    logic          rx_serr_ff;
    logic          rx_perr_ff;
    wire           rx_in    = i_rx ^ ctrl_ff.rx_line_invert; // RQ4
    wire           rx_en    = ctrl_ff.rx_enable_a | cmd_ff.rx_enable_b; // RQ2
    wire           rx_step  = tick & (rx_cnt_ff == '0);
    wire           rx_done  = rx_step & (rx_st_ff == AST_STOP);
    wire           rx_begin = (rx_st_ff == AST_IDLE) & rx_en & ~rx_in;

    // each bit is sampled half a bit after its leading edge
    // dropping both enables abandons a word in progress; nothing is transferred unless the stop bit is sampled in the first cycle with both clear
    // a start error does not abort the word; it shows at the transfer
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_st_ff   <= AST_IDLE;
            rx_cnt_ff  <= '0;
            rx_idx_ff  <= 3'h0;
            rx_sh_ff   <= `AST_DATA_RST;
            rx_serr_ff <= 1'b0;
            rx_perr_ff <= 1'b0;
        end else if (!rx_en) begin
            rx_st_ff <= AST_IDLE;
        end else if (rx_begin) begin
            rx_st_ff  <= AST_START; // RQ17
            rx_cnt_ff <= period >> 1;
            rx_sh_ff  <= `AST_DATA_RST;
        end else if (tick & (rx_cnt_ff != '0)) begin
            rx_cnt_ff <= rx_cnt_ff - 1'b1;
        end else if (rx_step) begin
            rx_cnt_ff <= period - 1'b1;
            case (rx_st_ff)
                AST_START: begin
                    rx_serr_ff <= rx_in; // RQ24
                    rx_st_ff   <= AST_DATA;
                    rx_idx_ff  <= 3'h0;
                end
                AST_DATA: begin
                    rx_sh_ff[rx_idx_ff] <= rx_in; // RQ15
                    if (rx_idx_ff == last_bit) begin
                        rx_perr_ff <= 1'b0;
                        rx_st_ff   <= cmd_ff.parity_enable ? AST_PARITY : AST_STOP;
                    end else begin
                        rx_idx_ff <= rx_idx_ff + 1'b1;
                    end
                end
                AST_PARITY: begin
                    rx_perr_ff <= rx_in ^ par_bit(rx_sh_ff, cmd_ff.word_length_sel, cmd_ff.parity_mode); // RQ24
                    rx_st_ff   <= AST_STOP;
                end
                default: begin
                    rx_st_ff <= AST_IDLE;
                end
            endcase
        end
    end

    // the transfer into the holding register wins over a read in the same cycle
    // overrun is flagged only when no read meets the transfer in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rxdata_ff  <= `AST_DATA_RST;
            rx_full_ff <= 1'b0;
            ovr_ff     <= 1'b0;
            serr_ff    <= 1'b0;
            perr_ff    <= 1'b0;
            ferr_ff    <= 1'b0;
        end else begin
            if (rx_done) begin
                rxdata_ff  <= rx_sh_ff; // RQ18
                rx_full_ff <= 1'b1;     // RQ18
                serr_ff    <= rx_serr_ff; // RQ24
                perr_ff    <= rx_perr_ff; // RQ24
                ferr_ff    <= ~rx_in;     // RQ25
            end else if (rd_rxd) begin
                rx_full_ff <= 1'b0; // RQ19
            end
            if (rx_done & rx_full_ff & ~rd_rxd) begin
                ovr_ff <= 1'b1; // RQ23
            end else if (wr_rxs) begin
                ovr_ff <= 1'b0; // RQ20
            end
        end
    end

    assign rxsta = '{unused:          2'h0,
                     rx_start_err:    serr_ff,
                     rx_parity_err:   perr_ff,
                     rx_frame_err:    ferr_ff,
                     rx_overrun_err:  ovr_ff,
                     rx_active:       (rx_st_ff != AST_IDLE), // RQ17
                     rx_holding_full: rx_full_ff};

    // ----------------------------------------
    // line out and interrupts
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_out_ff <= 1'b1;
            irq_ff    <= 2'h0;
        end else begin
            // echo takes the raw pin, so rx_line_invert never reaches the echoed line
            tx_out_ff <= (ctrl_ff.echo_enable ? i_rx : tx_line_ff) ^ ctrl_ff.tx_line_invert; // RQ1 RQ4
            irq_ff[1] <= tx_load; // RQ13 RQ21
            irq_ff[0] <= rx_done; // RQ21 RQ22
        end
    end

    assign o_tx                     = tx_out_ff;
    assign o_high_priority_irq_line = irq_ff;

endmodule

/* File: tb/ast_uart_assertions.sv */
// port checker for the serial transceiver, bound onto ast_uart
// assumes zero wait states; shadows the control register from bus writes
`timescale 1ns/1ps
`include "ast_params.svh"

module ast_uart_assertions (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [2:0]  i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic        i_rx,
    input wire logic        o_tx,
    input wire logic [1:0]  o_high_priority_irq_line
);
    import ast_pkg::*;
    // ----------------------------------------
    // bus shadow
    // ----------------------------------------
    logic         rd_ff;
    logic         rdc_ff;
    logic         wc_ff;
    ast_ctrl_type ctrl_ff;
    wire          take    = i_hsel && i_hready && i_htrans == `AST_HTRANS_NSEQ && i_hsize == `AST_HSIZE_WORD;
    wire          at_ctrl = i_haddr[7:2] == 6'h00;
    wire          tx_irq  = o_high_priority_irq_line[1];
    wire          rx_irq  = o_high_priority_irq_line[0];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_ff   <= 1'b0;
            rdc_ff  <= 1'b0;
            wc_ff   <= 1'b0;
            ctrl_ff <= `AST_CTRL_RST;
        end else begin
            rd_ff  <= take && !i_hwrite;
            rdc_ff <= take && !i_hwrite && at_ctrl;
            wc_ff  <= take && i_hwrite && at_ctrl;
            if (wc_ff) ctrl_ff <= ast_ctrl_type'(i_hwdata[7:0]);
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // load pulse first, start level within two cycles
    sequence tx_load_s;
        tx_irq && !ctrl_ff.echo_enable;
    endsequence
    sequence start_bit_s;
        ##[0:2] (o_tx == ctrl_ff.tx_line_invert);
    endsequence

    ready_high_a: assert property (o_hreadyout)
        else $error("hreadyout went low");
    resp_okay_a: assert property (!o_hresp)
        else $error("error response seen");
    rdata_idle_a: assert property (!rd_ff |-> o_hrdata == 32'h0000_0000)
        else $error("read data outside a read data phase");
    rdata_upper_a: assert property (o_hrdata[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");
    ctrl_read_a: assert property (rdc_ff |-> o_hrdata[7:0] == $past(ctrl_ff))
        else $error("control readback wrong");
    tx_irq_pulse_a: assert property (tx_irq |=> !tx_irq)
        else $error("transmit interrupt longer than a pulse");
    rx_irq_pulse_a: assert property (rx_irq |=> !rx_irq)
        else $error("receive interrupt longer than a pulse");
    tx_needs_en_a: assert property (tx_irq |-> ctrl_ff.tx_enable || $past(ctrl_ff.tx_enable))
        else $error("word loaded while transmit disabled");
    tx_start_a: assert property (tx_load_s |-> start_bit_s)
        else $error("no start bit after load");
    echo_path_a: assert property (ctrl_ff.echo_enable && $past(ctrl_ff.echo_enable)
        |-> o_tx == ($past(i_rx) ^ $past(ctrl_ff.tx_line_invert)))
        else $error("echo output wrong");
endmodule

bind ast_uart ast_uart_assertions i_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_rx(i_rx), .o_tx(o_tx), .o_high_priority_irq_line(o_high_priority_irq_line)
);

/* File: tb/ast_remote_model.sv */
// remote serial device: sends frames on rx, samples frames from tx
// assumes a fixed bit time in clock cycles; the line rests where the last frame or level left it
`timescale 1ns/1ps

module ast_remote_model #(
    parameter int BIT = 64
) (
    input  wire logic i_clk,
    input  wire logic i_tx,
    output logic      o_rx
);
    initial o_rx = 1'b1;

    // frm holds start bit in bit 0, then data lsb first, parity, stop; the last bit is held
    task automatic send(input logic [10:0] frm, input int n);
        for (int k = 0; k < n; k++) begin
            o_rx <= frm[k];
            repeat (BIT) @(posedge i_clk);
        end
    endtask

    task automatic level(input logic v);
        o_rx <= v;
    endtask

    // sample mid-bit; a wrong bit time drifts out of the sample window
    task automatic grab(output logic [10:0] w);
        @(posedge i_clk iff i_tx === 1'b0);
        repeat (BIT / 2) @(posedge i_clk);
        for (int k = 0; k < 11; k++) begin
            w[k] = i_tx;
            repeat (BIT) @(posedge i_clk);
        end
    endtask
endmodule

/* File: tb/ast_uart_tb_top.sv */
// testbench for the serial transceiver: register tests over ahb-lite
// assumes rc oscillator at a quarter of the clock, crystal at half; one bit is 64 cycles
`timescale 1ns/1ps
`include "ast_params.svh"

module ast_uart_tb_top;
    import ast_pkg::*;
    logic        i_clk;
    logic        i_rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [1:0]  div_ff;
    logic        rx;
    logic        tx;
    logic [1:0]  irq;
    logic [10:0] w;
    logic [31:0] q;
    int          n_fail;
    int          samples_checked;
    int          cyc;
    logic [7:0]  offs [7] = '{`AST_OFF_CTRL, `AST_OFF_CMD, `AST_OFF_TXDATA, `AST_OFF_TXSTA,
                              `AST_OFF_RXDATA, `AST_OFF_RXSTA, 8'h18};
    logic [7:0]  rstv [7] = '{`AST_CTRL_RST, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    ast_uart i_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
        .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_rc_osc(div_ff[1]),
        .i_xtal_osc(div_ff[0]), .i_rx(rx), .o_tx(tx), .o_high_priority_irq_line(irq)
    );
    ast_remote_model #(.BIT(64)) i_remote (.i_clk(i_clk), .i_tx(tx), .o_rx(rx));

    // ----------------------------------------
    // clock, oscillators, timeout
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        div_ff <= i_rstn ? div_ff + 2'h1 : 2'h0;
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= `AST_HTRANS_NSEQ;
        hwrite <= wr;
        hsize  <= `AST_HSIZE_WORD;
        @(posedge i_clk);
        while (hreadyout !== 1'b1) @(posedge i_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        @(posedge i_clk);
        while (hreadyout !== 1'b1) @(posedge i_clk);
        q = hrdata;
        @(posedge i_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffff_ffff);
        bus(1'b0, a, 8'h00);
        chk(q & m, exp);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {i_rstn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        bus(1'b1, 8'h18, 8'hff);
        bus(1'b1, `AST_OFF_RXDATA, 8'hff);
        for (int k = 0; k < 7; k++) rdchk(offs[k], {24'h00_0000, rstv[k]});
        // 8 bits, even parity, baud_code 111 at 16 edges per bit; transmitter held off
        bus(1'b1, `AST_OFF_CMD, 8'h07);
        bus(1'b1, `AST_OFF_CTRL, 8'h07);
        bus(1'b1, `AST_OFF_TXDATA, 8'ha5);
        rdchk(`AST_OFF_TXSTA, 32'h0000_0001);
        rdchk(`AST_OFF_TXDATA, 32'h0000_00a5);
        repeat (200) @(posedge i_clk);
        chk({31'h0000_0000, tx}, 32'h0000_0001);
        fork
            i_remote.grab(w);
            begin
                bus(1'b1, `AST_OFF_CTRL, 8'h27);
                repeat (100) @(posedge i_clk);
                rdchk(`AST_OFF_TXSTA, 32'h0000_0002);
            end
        join
        chk({21'h00_0000, w}, 32'h0000_054a);
        bus(1'b1, `AST_OFF_CTRL, 8'h67);
        i_remote.send(11'h478, 11);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0001);
        rdchk(`AST_OFF_RXDATA, 32'h0000_003c);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0000);
        // second enable alone; bad parity, then an unread word overwritten
        bus(1'b1, `AST_OFF_CTRL, 8'h27);
        bus(1'b1, `AST_OFF_CMD, 8'h47);
        i_remote.send(11'h678, 11);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0011);
        i_remote.send(11'h4b4, 11);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0005);
        bus(1'b1, `AST_OFF_RXSTA, 8'h00);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0001);
        rdchk(`AST_OFF_RXDATA, 32'h0000_005a);
        // low stop bit; the held low starts a word at once, which disabling aborts
        i_remote.send(11'h078, 11);
        rdchk(`AST_OFF_RXSTA, 32'h0000_000b);
        bus(1'b1, `AST_OFF_CMD, 8'h07);
        repeat (768) @(posedge i_clk);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0009);
        // crystal at prescale 001, odd parity, 7 bits, inverted rx; the unread word is overrun
        bus(1'b1, `AST_OFF_CTRL, 8'h17);
        bus(1'b1, `AST_OFF_CMD, 8'hca);
        i_remote.send(11'h095, 10);
        rdchk(`AST_OFF_RXSTA, 32'h0000_0005);
        rdchk(`AST_OFF_RXDATA, 32'h0000_0035);
        bus(1'b1, `AST_OFF_CTRL, 8'h8f);
        for (int v = 0; v < 2; v++) begin
            i_remote.level(v[0]);
            repeat (3) @(posedge i_clk);
            chk({31'h0000_0000, tx}, {31'h0000_0000, !v[0]});
        end
        complete_run();
    end
endmodule
